//--- core/vpg_cfg.svh
/*
 * Constants of the vertical pattern group control slice: serial frame
 * layout, register address, field positions, codes and reset value.
 * Assumes it is included by its bare name from the core sources.
 */
`ifndef VPG_CFG_SVH
`define VPG_CFG_SVH

// Serial frame: address first, then data, both least significant bit first.
`define VPG_ADDR_W 8
`define VPG_DATA_W 26
`define VPG_CTRL_ADDR 8'h00

// Field positions inside the 26-bit control word.
`define VPG_HOLD_LSB 2
`define VPG_MASK_LSB 6
`define VPG_JOIN_LSB 10
`define VPG_REP_LSB 14
`define VPG_LASTLEN_LSB 16
`define VPG_TOG5_LSB 20
`define VPG_HORIZONTAL_BLANKING_LSB 24
`define VPG_HORIZONTAL_BLANKING_MSB 25

// Codes.
`define VPG_JOIN_ON 4'h1
`define VPG_REP_SINGLE 2'h0
`define VPG_REP_TWO 2'h1
`define VPG_REP_THREE 2'h2
`define VPG_REP_FOUR 2'h3
`define VPG_HORIZONTAL_BLANKING_MODE0 2'h0
`define VPG_HORIZONTAL_BLANKING_MODE1 2'h1
`define VPG_HORIZONTAL_BLANKING_MODE2 2'h2
`define VPG_HORIZONTAL_BLANKING_TEST 2'h3

// Reset value of the stored fields [25:2].
`define VPG_CTRL_RESET 24'h000000

// Sequencer position counter: longest cycle is six steps.
`define VPG_POS_LAST 3'h5

`endif

//--- core/vpg_pkg.sv
/*
 * Types of the vertical pattern group control slice.
 * Assumes vpg_cfg.svh is compiled alongside; the package itself holds no numbers.
 */
package vpg_pkg;

    // Stored control fields, laid out exactly as bits [25:2] of the word.
    typedef struct packed {
        logic [1:0] hblank_select;
        logic [3:0] fifth_toggle_enable;
        logic [3:0] final_repeat_length_enable;
        logic [1:0] alternation_repeat_select;
        logic [3:0] group_join_select;
        logic [3:0] freeze_resume_mask_enable;
        logic [3:0] hold_enable;
    } vpg_ctrl_t;

    // Serial control port frame states.
    typedef enum logic [0:0] {
        VPG_SP_IDLE,
        VPG_SP_SHIFT
    } vpg_sp_state_t;

endpackage

//--- core/vpg_alt_seq.sv
/*
 * Alternation sequencer of one vertical pattern group: gives the pattern
 * index to use for the next repetition, following the repeat mode.
 * Assumes step and restart are one-cycle pulses from the pattern sequencer.
 */
`timescale 1ns/1ps
`default_nettype none
`include "vpg_cfg.svh"

module vpg_alt_seq #(
    parameter bit IS_GROUP_A = 1'b0
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Control
    input wire logic [1:0] repeat_select,
    input wire logic restart,
    input wire logic step,
    // Result
    output logic [1:0] pattern_index_r
);

    logic [2:0] pos_r;
    logic [2:0] pos_nxt;

    function automatic logic [2:0] last_pos(input logic [1:0] mode, input bit grp_a);
        case (mode)
            `VPG_REP_SINGLE: last_pos = 3'h0;
            `VPG_REP_TWO: last_pos = 3'h1;
            `VPG_REP_THREE: last_pos = grp_a ? 3'h2 : `VPG_POS_LAST;
            default: last_pos = grp_a ? 3'h3 : 3'h1;
        endcase
    endfunction

    function automatic logic [1:0] index_of(input logic [1:0] mode, input bit grp_a,
                                            input logic [2:0] pos);
        case (mode)
            `VPG_REP_SINGLE: index_of = 2'h0;
            `VPG_REP_TWO: index_of = {1'b0, pos[0]};
            // Groups B to D walk 0,1,1,0,1,1: zero only at positions 0 and 3.
            `VPG_REP_THREE: index_of = grp_a ? pos[1:0] :
                                {1'b0, (pos != 3'h0) && (pos != 3'h3)};
            default: index_of = grp_a ? pos[1:0] : {1'b0, pos[0]};
        endcase
    endfunction

    always_comb begin
        if (restart) begin
            pos_nxt = 3'h0;
        end else if (step) begin
            // A mode change mid-cycle may leave pos past the new end; wrap then.
            pos_nxt = (pos_r >= last_pos(repeat_select, IS_GROUP_A)) ? 3'h0 : pos_r + 3'h1;
        end else begin
            pos_nxt = pos_r;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pos_r <= 3'h0;
        end else begin
            pos_r <= pos_nxt;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            pattern_index_r <= 2'h0;
        end else begin
            pattern_index_r <= index_of(repeat_select, IS_GROUP_A, pos_nxt);
        end
    end

endmodule

`default_nettype wire

//--- core/vpg_ctrl.sv
/*
 * Vertical pattern group control register, written over the 3-wire serial
 * control port, with the per-group alternation sequencers it steers.
 * Assumes the serial pins are already synchronous to mclk and that each
 * serial clock high and low phase lasts at least one mclk period.
 */
`timescale 1ns/1ps
`default_nettype none
`include "vpg_cfg.svh"

module vpg_ctrl
    import vpg_pkg::*;
#(
    parameter int ADDR_W = `VPG_ADDR_W,
    parameter int DATA_W = `VPG_DATA_W
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Serial control port
    input wire logic scp_load_n,
    input wire logic scp_clk,
    input wire logic scp_data,
    // Pattern sequencer events: one restart for all groups, one step bit per group, bit 0 is group A
    input wire logic field_restart,
    input wire logic [3:0] repeat_step,
    // Control outputs
    output vpg_ctrl_t ctrl_r,
    output logic group_join_active_r,
    output logic hblank_test_code_r,
    output logic [3:0][1:0] pattern_index_r
);

    localparam int FRAME_W = ADDR_W + DATA_W;
    localparam int CNT_W = $clog2(FRAME_W + 2);

    // The field layout is fixed by vpg_ctrl_t, so only the address width may vary.
    if (DATA_W != `VPG_DATA_W || ADDR_W < 1 || ADDR_W > 16) begin : gen_width_check
        $error("vpg_ctrl: unsupported serial frame widths");
    end

    vpg_sp_state_t sp_state_r;
    logic scp_clk_d_r;
    logic [FRAME_W-1:0] shift_r;
    logic [CNT_W-1:0] bit_cnt_r;
    logic sclk_rise;
    logic frame_end;
    logic commit;
    vpg_ctrl_t word_nxt;

    assign sclk_rise = scp_clk && !scp_clk_d_r;
    assign frame_end = (sp_state_r == VPG_SP_SHIFT) && scp_load_n;
    // A frame of the wrong length or for another register is dropped whole.
    assign commit = frame_end && (bit_cnt_r == CNT_W'(FRAME_W))
                    && (shift_r[ADDR_W-1:0] == ADDR_W'(`VPG_CTRL_ADDR));
    assign word_nxt = vpg_ctrl_t'(shift_r[FRAME_W-1 -: DATA_W-`VPG_HOLD_LSB]);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            scp_clk_d_r <= 1'b0;
        end else begin
            scp_clk_d_r <= scp_clk;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            sp_state_r <= VPG_SP_IDLE;
        end else begin
            case (sp_state_r)
                VPG_SP_IDLE: begin
                    if (!scp_load_n) begin
                        sp_state_r <= VPG_SP_SHIFT;
                    end
                end
                VPG_SP_SHIFT: begin
                    if (scp_load_n) begin
                        sp_state_r <= VPG_SP_IDLE;
                    end
                end
                default: begin
                    sp_state_r <= VPG_SP_IDLE;
                end
            endcase
        end
    end

    // Bits arrive least significant first, so each one enters at the top.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            shift_r <= '0;
            bit_cnt_r <= '0;
        end else if (sp_state_r == VPG_SP_IDLE) begin
            bit_cnt_r <= '0;
        end else if (!scp_load_n && sclk_rise) begin
            shift_r <= {scp_data, shift_r[FRAME_W-1:1]};
            // Saturate one past a full frame so overlong frames stay refused.
            if (bit_cnt_r != CNT_W'(FRAME_W + 1)) begin
                bit_cnt_r <= bit_cnt_r + 1'b1;
            end
        end
    end

    // Field order in vpg_ctrl_t puts group A on bit 0 of every group field.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= vpg_ctrl_t'(`VPG_CTRL_RESET);
        end else if (commit) begin
            ctrl_r <= word_nxt;
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            group_join_active_r <= 1'b0;
        end else if (commit) begin
            group_join_active_r <= (word_nxt.group_join_select == `VPG_JOIN_ON);
        end
    end

    // The test code is stored as written; the flag lets the blanking logic
    // fall back to mode 0 instead of entering an untested mode.
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            hblank_test_code_r <= 1'b0;
        end else if (commit) begin
            hblank_test_code_r <= (word_nxt.hblank_select == `VPG_HORIZONTAL_BLANKING_TEST);
        end
    end

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : gen_seq
            vpg_alt_seq #(
                .IS_GROUP_A(g == 0)
            ) u_seq (
                .mclk(mclk),
                .rst_n(rst_n),
                .repeat_select(ctrl_r.alternation_repeat_select),
                .restart(field_restart),
                .step(repeat_step[g]),
                .pattern_index_r(pattern_index_r[g])
            );
        end
    endgenerate

endmodule

`default_nettype wire

//--- tb/vpg_step_model.sv
/* Model of the pattern sequencer that sends step and restart pulses.
   Assumes the bench calls pulse from one process only. */
`timescale 1ns/1ps
`default_nettype none
module vpg_step_model (
    // Clock
    input wire logic mclk,
    // Pulses to the control block
    output logic field_restart,
    output logic [3:0] repeat_step
);
    initial begin
        field_restart = 1'b0;
        repeat_step = 4'h0;
    end
    // One-cycle pulse; the gap gives both prompt and slow spacing.
    task automatic pulse(input logic r, input logic [3:0] m, input int gap);
        @(posedge mclk);
        field_restart <= r;
        repeat_step <= m;
        @(posedge mclk);
        field_restart <= 1'b0;
        repeat_step <= 4'h0;
        repeat (gap) @(posedge mclk);
    endtask
endmodule
`default_nettype wire

//--- tb/vpg_ctrl_asserts.sv
/* Checker of vpg_ctrl flags, register hold and sequencer steps.
   Assumes it is bound to vpg_ctrl and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module vpg_ctrl_asserts
    import vpg_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // Watched inputs
    input wire logic scp_load_n,
    input wire logic field_restart,
    input wire logic [3:0] repeat_step,
    // Watched outputs
    input wire vpg_ctrl_t ctrl_r,
    input wire logic group_join_active_r,
    input wire logic hblank_test_code_r,
    input wire logic [3:0][1:0] pattern_index_r
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    logic [1:0] md;
    logic [1:0] ia;
    assign md = ctrl_r.alternation_repeat_select;
    assign ia = pattern_index_r[0];
    property p_join; group_join_active_r == (ctrl_r.group_join_select == 4'h1); endproperty
    a_join: assert property (p_join) else $error("Join flag wrong");
    property p_test; hblank_test_code_r == (ctrl_r.hblank_select == 2'h3); endproperty
    a_test: assert property (p_test) else $error("Test flag wrong");
    // Three low samples in a row mean no commit can land now.
    property p_hold; !scp_load_n && !$past(scp_load_n) && !$past(scp_load_n, 2) |-> $stable(ctrl_r); endproperty
    a_hold: assert property (p_hold) else $error("Register changed in frame");
    property p_rst; field_restart |=> pattern_index_r == 8'h00; endproperty
    a_rst: assert property (p_rst) else $error("Restart missed");
    property p_two; md == 2'h1 && repeat_step[1] && !field_restart && pattern_index_r[1] == 2'h0
        |=> pattern_index_r[1] == 2'h1; endproperty
    a_two: assert property (p_two) else $error("Two-pattern step wrong");
    property p_thra; md == 2'h2 && repeat_step[0] && !field_restart && ia == 2'h2 |=> ia == 2'h0;
    endproperty
    a_thra: assert property (p_thra) else $error("Three-pattern wrap wrong");
    property p_thrb; md == 2'h2 && repeat_step[2] && !field_restart && pattern_index_r[2] == 2'h0
        |=> pattern_index_r[2] == 2'h1; endproperty
    a_thrb: assert property (p_thrb) else $error("Walk step wrong");
    property p_four; md == 2'h3 && repeat_step[0] && !field_restart |=> ia == $past(ia) + 2'h1;
    endproperty
    a_four: assert property (p_four) else $error("Four-pattern step wrong");
endmodule
bind vpg_ctrl vpg_ctrl_asserts vpg_ctrl_asserts_inst (.mclk(mclk), .rst_n(rst_n),
    .scp_load_n(scp_load_n), .field_restart(field_restart), .repeat_step(repeat_step),
    .ctrl_r(ctrl_r), .group_join_active_r(group_join_active_r),
    .hblank_test_code_r(hblank_test_code_r), .pattern_index_r(pattern_index_r));
`default_nettype wire

//--- tb/vpg_ctrl_bench.sv
/* Self-checking bench of vpg_ctrl: serial writes, refused frames, steps.
   Assumes the core, the step model and the checker are compiled first. */
`timescale 1ns/1ps
`default_nettype none
module vpg_ctrl_bench;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic scp_load_n = 1'b1;
    logic scp_clk = 1'b0;
    logic scp_data = 1'b0;
    wire logic field_restart;
    wire logic [3:0] repeat_step;
    logic [23:0] ctrl_r;
    logic join_r;
    logic test_r;
    logic [3:0][1:0] idx_r;
    logic [23:0] exp_c = 24'h000000;
    int error_cnt = 0;
    int n_checks = 0;
    int cyc = 0;
    int pos[4];
    initial begin
        forever #2 mclk = ~mclk;
    end
    vpg_ctrl vpg_ctrl_inst (.mclk(mclk), .rst_n(rst_n), .scp_load_n(scp_load_n),
        .scp_clk(scp_clk), .scp_data(scp_data), .field_restart(field_restart),
        .repeat_step(repeat_step), .ctrl_r(ctrl_r), .group_join_active_r(join_r),
        .hblank_test_code_r(test_r), .pattern_index_r(idx_r));
    vpg_step_model vpg_step_model_inst (.mclk(mclk), .field_restart(field_restart),
        .repeat_step(repeat_step));
    task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wrap_up();
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Address then data, LSB first; a wrong count or address must leave the word alone.
    task automatic frame(input logic [7:0] a, input logic [25:0] d, input int n);
        logic [33:0] v;
        v = {d, a};
        @(posedge mclk) scp_load_n <= 1'b0;
        for (int i = 0; i < n; i++) begin
            @(posedge mclk) scp_clk <= 1'b0;
            scp_data <= v[i % 34];
            @(posedge mclk) scp_clk <= 1'b1;
        end
        @(posedge mclk) scp_clk <= 1'b0;
        @(posedge mclk) scp_load_n <= 1'b1;
        repeat (3) @(posedge mclk);
        #1;
        if (a == 8'h00 && n == 34) exp_c = d[25:2];
        chk("ctrl", exp_c, ctrl_r);
        chk("join", 24'(exp_c[11:8] == 4'h1), 24'(join_r));
        chk("test", 24'(exp_c[23:22] == 2'h3), 24'(test_r));
    endtask
    function automatic int seq_len(input logic [1:0] m, input int g);
        case (m)
            2'h0: return 1;
            2'h1: return 2;
            2'h2: return (g == 0) ? 3 : 6;
            default: return (g == 0) ? 4 : 2;
        endcase
    endfunction
    task automatic step(input logic r, input logic [3:0] m, input logic [1:0] md);
        logic [1:0] e;
        vpg_step_model_inst.pulse(r, m, $urandom_range(1, 0));
        #1;
        for (int g = 0; g < 4; g++) begin
            if (r) pos[g] = 0;
            else if (m[g]) pos[g] = (pos[g] + 1) % seq_len(md, g);
            e = (md == 2'h2 && g != 0) ? 2'(pos[g] % 3 != 0) : 2'(pos[g]);
            chk("index", 24'(e), 24'(idx_r[g]));
        end
    endtask
    initial begin
        logic [25:0] rd;
        void'($urandom(60526));
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        frame(8'h00, 26'h0000400, 34);
        frame(8'h00, 26'h3000800, 34);
        frame(8'h01, 26'h3FFFFFF, 34);
        frame(8'h00, 26'h3FFFFFF, 33);
        frame(8'h00, 26'h3FFFFFF, 35);
        repeat (10) begin
            rd = 26'($urandom);
            // Random software writes keep clear of the reserved blanking code.
            if (rd[25:24] == 2'h3) rd[25] = 1'b0;
            frame(8'h00, rd, 34);
        end
        // Mid-run reset returns every output to its reset value.
        @(posedge mclk) rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        #1;
        exp_c = 24'h000000;
        chk("reset ctrl", exp_c, ctrl_r);
        chk("reset flags", 24'h000000, {22'h000000, join_r, test_r});
        chk("reset index", 24'h000000, 24'(idx_r));
        @(posedge mclk) rst_n <= 1'b1;
        for (int md = 0; md < 4; md++) begin
            frame(8'h00, (26'(md) << 14) | (26'(md % 3) << 24), 34);
            step(1'b1, 4'h0, 2'(md));
            repeat (9) step(1'b0, 4'($urandom_range(15, 0)) | 4'h7, 2'(md));
            step(1'b1, 4'hF, 2'(md));
        end
        wrap_up();
    end
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc > 20000) begin
            error_cnt++;
            wrap_up();
        end
    end
endmodule
`default_nettype wire
